// ===== hw/blr_consts.svh
// constants of the byte load group decoder
`ifndef BLR_CONSTS_SVH
`define BLR_CONSTS_SVH
`define BLR_OP_PFX_IDX1 8'hdd
`define BLR_OP_PFX_IDX2 8'hfd
`define BLR_OP_PFX_EXT 8'hed
`define BLR_OP_COPY_B_TO_C 8'h48
`define BLR_OP_STORE_D_PRIMARY 8'h72
`define BLR_OP_IMM_TO_H 8'h26
`define BLR_OP_HALT 8'h76
`define BLR_OP_LOAD_A_BC 8'h0a
`define BLR_OP_LOAD_A_DE 8'h1a
`define BLR_OP_STORE_A_BC 8'h02
`define BLR_OP_STORE_A_DE 8'h12
`define BLR_OP_LOAD_A_EXT 8'h3a
`define BLR_OP_STORE_A_EXT 8'h32
`define BLR_OP_IDX_STORE_IMM 8'h36
`define BLR_OP_LOAD_A_IVEC 8'h57
`define BLR_OP_LOAD_A_REFR 8'h5f
`define BLR_OP_STORE_A_IVEC 8'h47
`define BLR_OP_STORE_A_REFR 8'h4f
`define BLR_GRP_HI 7
`define BLR_GRP_LO 6
`define BLR_DST_HI 5
`define BLR_DST_LO 3
`define BLR_SRC_HI 2
`define BLR_SRC_LO 0
`define BLR_SIGN_BIT 7
`define BLR_GRP_REG 2'h1
`define BLR_GRP_ZERO 2'h0
`define BLR_FLD_MEM 3'h6
`define BLR_REG_A 3'h7
`define BLR_REG_B 3'h0
`define BLR_REG_C 3'h1
`define BLR_REG_D 3'h2
`define BLR_REG_H 3'h4
`define BLR_SPC_IVEC 3'h0
`define BLR_SPC_REFR 3'h1
`define BLR_LEN_ONE 3'h1
`define BLR_LEN_TWO 3'h2
`define BLR_LEN_THREE 3'h3
`define BLR_LEN_FOUR 3'h4
`endif

// ===== hw/blr_pkg.sv
// types of the byte load group decoder
`default_nettype none
package blr_pkg;
   typedef enum logic [3:0] {
      BLR_K_NONE, BLR_K_REG_REG, BLR_K_REG_IMM, BLR_K_LOAD_IND, BLR_K_STORE_IND,
      BLR_K_STORE_IND_IMM, BLR_K_LOAD_IDX, BLR_K_STORE_IDX, BLR_K_STORE_IDX_IMM,
      BLR_K_LOAD_EXT, BLR_K_STORE_EXT, BLR_K_LOAD_SPC, BLR_K_STORE_SPC
   } blr_kind_t;
   typedef enum logic [2:0] {
      BLR_P_NONE, BLR_P_PRIMARY, BLR_P_BC, BLR_P_DE, BLR_P_IDX1, BLR_P_IDX2, BLR_P_ABS
   } blr_ptr_t;
   typedef struct packed {
      blr_kind_t kind;
      blr_ptr_t ptr;
      logic [2:0] dst;
      logic [2:0] src;
      logic [7:0] imm;
      logic [7:0] disp;
      logic [15:0] addr;
      logic [2:0] len;
   } blr_res_t;
endpackage : blr_pkg
`default_nettype wire

// ===== hw/blr_decoder.sv
// byte load group decoder: opcode and operand sequencing
`include "blr_consts.svh"
`default_nettype none
// Overview of operation
// [RL1] opcode 48h copies register B into register C.
// [RL2] opcode taken in fetch cycle; register copies need no more bytes.
// [RL3] single byte 72 stores D at the primary pointer pair address.
// [RL4] indexed loads are three bytes; signed displacement added to index.
// [RL5] accumulator extended load and store are three bytes: opcode, two address.
// [RL6] first address byte is low half, second is high half.
// [RL7] immediate register loads are two bytes; second byte is the literal.
// [RL8] indexed displacement comes right after opcode, before immediate data.
// [RL9] displacement is signed; index register itself is never changed.
// [RL10] register copy fields: destination bits 5:3, source 2:0, top bits 01.
module blr_decoder (
   input wire logic sys_clk, // cpu clock
   input wire logic rst, // synchronous reset
   input wire logic fetch_valid, // fetched byte present
   input wire logic [7:0] fetch_byte, // fetched byte
   input wire logic [15:0] first_index_pointer, // index pointer one
   input wire logic [15:0] second_index_pointer, // index pointer two
   output logic opcode_fetch_cycle, // next byte is an opcode
   output logic dec_done, // one-cycle decode pulse
   output logic dec_bad, // one-cycle unknown opcode pulse
   output blr_pkg::blr_res_t dec_res // decoded load operation
);
   import blr_pkg::*;

   typedef enum logic [2:0] {
      S_OPC, S_PFX, S_EXT, S_DISP, S_IMM, S_ADR_LO, S_ADR_HI
   } blr_state_t;

   blr_state_t st_ff, nxt_st;
   blr_res_t wrk_ff, nxt_wrk, res_ff, nxt_res;
   logic done_ff, nxt_done, bad_ff, nxt_bad, opf_ff, nxt_opf;
   logic [7:0] lo_ff, nxt_lo;

   always_comb begin
      logic fin;
      logic [15:0] idx;
      fin = 1'b0;
      idx = (wrk_ff.ptr == BLR_P_IDX2) ? second_index_pointer : first_index_pointer;
      nxt_st = st_ff;
      nxt_wrk = wrk_ff;
      nxt_res = res_ff;
      nxt_lo = lo_ff;
      nxt_bad = 1'b0;
      if (fetch_valid) begin
         nxt_wrk.len = wrk_ff.len + 3'h1;
         unique case (st_ff)
            S_OPC: begin
               nxt_wrk = '0;
               nxt_wrk.len = `BLR_LEN_ONE;
               if (fetch_byte == `BLR_OP_PFX_IDX1 || fetch_byte == `BLR_OP_PFX_IDX2) begin
                  nxt_wrk.ptr = (fetch_byte == `BLR_OP_PFX_IDX1) ? BLR_P_IDX1 : BLR_P_IDX2;
                  nxt_st = S_PFX;
               end else if (fetch_byte == `BLR_OP_PFX_EXT) begin
                  nxt_st = S_EXT;
               // [RL10] register field split
               end else if (fetch_byte[`BLR_GRP_HI:`BLR_GRP_LO] == `BLR_GRP_REG &&
                            fetch_byte != `BLR_OP_HALT) begin
                  nxt_wrk.dst = fetch_byte[`BLR_DST_HI:`BLR_DST_LO];
                  nxt_wrk.src = fetch_byte[`BLR_SRC_HI:`BLR_SRC_LO];
                  // [RL1] [RL3] memory forms via pair
                  if (nxt_wrk.src == `BLR_FLD_MEM) begin
                     nxt_wrk.kind = BLR_K_LOAD_IND;
                     nxt_wrk.ptr = BLR_P_PRIMARY;
                  end else if (nxt_wrk.dst == `BLR_FLD_MEM) begin
                     nxt_wrk.kind = BLR_K_STORE_IND;
                     nxt_wrk.ptr = BLR_P_PRIMARY;
                  end else begin
                     nxt_wrk.kind = BLR_K_REG_REG;
                  end
                  // [RL2] single byte, done now
                  fin = 1'b1;
               // [RL7] immediate follows opcode
               end else if (fetch_byte[`BLR_GRP_HI:`BLR_GRP_LO] == `BLR_GRP_ZERO &&
                            fetch_byte[`BLR_SRC_HI:`BLR_SRC_LO] == `BLR_FLD_MEM) begin
                  nxt_wrk.dst = fetch_byte[`BLR_DST_HI:`BLR_DST_LO];
                  if (nxt_wrk.dst == `BLR_FLD_MEM) begin
                     nxt_wrk.kind = BLR_K_STORE_IND_IMM;
                     nxt_wrk.ptr = BLR_P_PRIMARY;
                  end else begin
                     nxt_wrk.kind = BLR_K_REG_IMM;
                  end
                  nxt_st = S_IMM;
               end else if (fetch_byte == `BLR_OP_LOAD_A_BC ||
                            fetch_byte == `BLR_OP_LOAD_A_DE) begin
                  nxt_wrk.kind = BLR_K_LOAD_IND;
                  nxt_wrk.dst = `BLR_REG_A;
                  nxt_wrk.ptr = (fetch_byte == `BLR_OP_LOAD_A_BC) ? BLR_P_BC : BLR_P_DE;
                  fin = 1'b1;
               end else if (fetch_byte == `BLR_OP_STORE_A_BC ||
                            fetch_byte == `BLR_OP_STORE_A_DE) begin
                  nxt_wrk.kind = BLR_K_STORE_IND;
                  nxt_wrk.src = `BLR_REG_A;
                  nxt_wrk.ptr = (fetch_byte == `BLR_OP_STORE_A_BC) ? BLR_P_BC : BLR_P_DE;
                  fin = 1'b1;
               // [RL5] two address bytes follow
               end else if (fetch_byte == `BLR_OP_LOAD_A_EXT ||
                            fetch_byte == `BLR_OP_STORE_A_EXT) begin
                  nxt_wrk.kind = (fetch_byte == `BLR_OP_LOAD_A_EXT) ? BLR_K_LOAD_EXT
                                                                    : BLR_K_STORE_EXT;
                  nxt_wrk.dst = `BLR_REG_A;
                  nxt_wrk.src = `BLR_REG_A;
                  nxt_wrk.ptr = BLR_P_ABS;
                  nxt_st = S_ADR_LO;
               end else begin
                  nxt_bad = 1'b1;
               end
            end
            S_PFX: begin
               // [RL4] [RL8] displacement next
               nxt_st = S_DISP;
               if (fetch_byte == `BLR_OP_IDX_STORE_IMM) begin
                  nxt_wrk.kind = BLR_K_STORE_IDX_IMM;
               end else if (fetch_byte[`BLR_GRP_HI:`BLR_GRP_LO] == `BLR_GRP_REG &&
                            fetch_byte != `BLR_OP_HALT &&
                            fetch_byte[`BLR_SRC_HI:`BLR_SRC_LO] == `BLR_FLD_MEM) begin
                  nxt_wrk.kind = BLR_K_LOAD_IDX;
                  nxt_wrk.dst = fetch_byte[`BLR_DST_HI:`BLR_DST_LO];
               end else if (fetch_byte[`BLR_GRP_HI:`BLR_GRP_LO] == `BLR_GRP_REG &&
                            fetch_byte != `BLR_OP_HALT &&
                            fetch_byte[`BLR_DST_HI:`BLR_DST_LO] == `BLR_FLD_MEM) begin
                  nxt_wrk.kind = BLR_K_STORE_IDX;
                  nxt_wrk.src = fetch_byte[`BLR_SRC_HI:`BLR_SRC_LO];
               end else begin
                  nxt_bad = 1'b1;
                  nxt_st = S_OPC;
               end
            end
            S_EXT: begin
               nxt_st = S_OPC;
               fin = 1'b1;
               unique case (fetch_byte)
                  `BLR_OP_LOAD_A_IVEC, `BLR_OP_LOAD_A_REFR: begin
                     nxt_wrk.kind = BLR_K_LOAD_SPC;
                     nxt_wrk.dst = `BLR_REG_A;
                     nxt_wrk.src = (fetch_byte == `BLR_OP_LOAD_A_IVEC) ? `BLR_SPC_IVEC
                                                                       : `BLR_SPC_REFR;
                  end
                  `BLR_OP_STORE_A_IVEC, `BLR_OP_STORE_A_REFR: begin
                     nxt_wrk.kind = BLR_K_STORE_SPC;
                     nxt_wrk.src = `BLR_REG_A;
                     nxt_wrk.dst = (fetch_byte == `BLR_OP_STORE_A_IVEC) ? `BLR_SPC_IVEC
                                                                        : `BLR_SPC_REFR;
                  end
                  default: begin
                     fin = 1'b0;
                     nxt_bad = 1'b1;
                  end
               endcase
            end
            S_DISP: begin
               // [RL9] signed add, index untouched
               nxt_wrk.disp = fetch_byte;
               nxt_wrk.addr = idx + {{8{fetch_byte[`BLR_SIGN_BIT]}}, fetch_byte};
               if (wrk_ff.kind == BLR_K_STORE_IDX_IMM) begin
                  nxt_st = S_IMM;
               end else begin
                  fin = 1'b1;
               end
            end
            S_IMM: begin
               nxt_wrk.imm = fetch_byte;
               fin = 1'b1;
            end
            S_ADR_LO: begin
               // [RL6] low half first
               nxt_lo = fetch_byte;
               nxt_st = S_ADR_HI;
            end
            S_ADR_HI: begin
               nxt_wrk.addr = {fetch_byte, lo_ff};
               fin = 1'b1;
            end
         endcase
         if (fin) begin
            nxt_st = S_OPC;
            nxt_res = nxt_wrk;
         end
      end
      nxt_done = fin;
      nxt_opf = (nxt_st == S_OPC);
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_ff <= S_OPC;
         wrk_ff <= '0;
         res_ff <= '0;
         lo_ff <= 8'h00;
         done_ff <= 1'b0;
         bad_ff <= 1'b0;
         opf_ff <= 1'b1;
      end else begin
         st_ff <= nxt_st;
         wrk_ff <= nxt_wrk;
         res_ff <= nxt_res;
         lo_ff <= nxt_lo;
         done_ff <= nxt_done;
         bad_ff <= nxt_bad;
         opf_ff <= nxt_opf;
      end
   end

   assign opcode_fetch_cycle = opf_ff;
   assign dec_done = done_ff;
   assign dec_bad = bad_ff;
   assign dec_res = res_ff;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   AST_COPY_B_TO_C: assert property ( // [RL1]
      st_ff == S_OPC && fetch_valid && fetch_byte == `BLR_OP_COPY_B_TO_C |=>
      done_ff && res_ff.kind == BLR_K_REG_REG && res_ff.dst == `BLR_REG_C &&
      res_ff.src == `BLR_REG_B) else $error("48h not decoded as copy b to c");
   AST_REG_ONE_BYTE: assert property ( // [RL2]
      done_ff && res_ff.kind == BLR_K_REG_REG |-> res_ff.len == `BLR_LEN_ONE && opf_ff)
      else $error("register copy not single byte");
   AST_STORE_D: assert property ( // [RL3]
      st_ff == S_OPC && fetch_valid && fetch_byte == `BLR_OP_STORE_D_PRIMARY |=>
      done_ff && res_ff.kind == BLR_K_STORE_IND && res_ff.ptr == BLR_P_PRIMARY &&
      res_ff.src == `BLR_REG_D) else $error("72 not decoded as store d");
   AST_IDX_THREE: assert property ( // [RL4]
      done_ff && (res_ff.kind == BLR_K_LOAD_IDX || res_ff.kind == BLR_K_STORE_IDX) |->
      res_ff.len == `BLR_LEN_THREE) else $error("indexed load not three bytes");
   AST_EXT_THREE: assert property ( // [RL5]
      done_ff && (res_ff.kind == BLR_K_LOAD_EXT || res_ff.kind == BLR_K_STORE_EXT) |->
      res_ff.len == `BLR_LEN_THREE && res_ff.ptr == BLR_P_ABS)
      else $error("extended load not three bytes");
   AST_ADDR_LO_FIRST: assert property ( // [RL6]
      st_ff == S_ADR_LO && fetch_valid |=> st_ff == S_ADR_HI && lo_ff == $past(fetch_byte))
      else $error("first address byte not held as low half");
   AST_ADDR_ORDER: assert property ( // [RL6]
      st_ff == S_ADR_HI && fetch_valid |=>
      done_ff && res_ff.addr == {$past(fetch_byte), lo_ff})
      else $error("address halves out of order");
   AST_IMM_H: assert property ( // [RL7]
      st_ff == S_OPC && fetch_valid && fetch_byte == `BLR_OP_IMM_TO_H ##1
      fetch_valid |=> done_ff && res_ff.dst == `BLR_REG_H &&
      res_ff.imm == $past(fetch_byte) && res_ff.len == `BLR_LEN_TWO)
      else $error("immediate load of h wrong");
   AST_DISP_FIRST: assert property ( // [RL8]
      done_ff && res_ff.kind == BLR_K_STORE_IDX_IMM |-> res_ff.len == `BLR_LEN_FOUR)
      else $error("indexed immediate store not four bytes");
   AST_SIGNED_DISP: assert property ( // [RL9]
      st_ff == S_DISP && fetch_valid && wrk_ff.ptr == BLR_P_IDX1 &&
      wrk_ff.kind != BLR_K_STORE_IDX_IMM |=> done_ff && res_ff.addr ==
      $past(first_index_pointer) +
      {{8{$past(fetch_byte[`BLR_SIGN_BIT])}}, $past(fetch_byte)})
      else $error("indexed address not signed sum");
   AST_FIELDS: assert property ( // [RL10]
      st_ff == S_OPC && fetch_valid &&
      fetch_byte[`BLR_GRP_HI:`BLR_GRP_LO] == `BLR_GRP_REG &&
      fetch_byte[`BLR_DST_HI:`BLR_DST_LO] != `BLR_FLD_MEM &&
      fetch_byte[`BLR_SRC_HI:`BLR_SRC_LO] != `BLR_FLD_MEM |=>
      res_ff.dst == $past(fetch_byte[`BLR_DST_HI:`BLR_DST_LO]) &&
      res_ff.src == $past(fetch_byte[`BLR_SRC_HI:`BLR_SRC_LO]))
      else $error("register fields misdecoded");

   COV_IDX_IMM: cover property (done_ff && res_ff.kind == BLR_K_STORE_IDX_IMM);
   COV_EXT: cover property (done_ff && res_ff.kind == BLR_K_LOAD_EXT);
   COV_BAD: cover property (bad_ff);
endmodule : blr_decoder
`default_nettype wire

// ===== verification/blr_fetch_model.sv
// fetch sequencer model feeding program bytes to the decoder
`default_nettype none
module blr_fetch_model (
   input wire logic sys_clk, // cpu clock
   input wire logic rst, // synchronous reset
   input wire logic slow, // insert random stalls
   output logic fetch_valid = 1'b0, // byte present
   output logic [7:0] fetch_byte = 8'h00 // program byte
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem_q[$];
   task automatic put(input logic [7:0] b);
      mem_q.push_back(b);
   endtask : put
   always @(posedge sys_clk) begin
      #1;
      if (rst === 1'b0 && mem_q.size() > 0 && !(slow && $urandom_range(2) == 0)) begin
         fetch_valid = 1'b1;
         fetch_byte = mem_q.pop_front();
      end else begin
         // released line inverts the held byte on each idle cycle
         fetch_valid = 1'b0;
         fetch_byte = ~fetch_byte;
      end
   end
endmodule : blr_fetch_model
`default_nettype wire

// ===== verification/tb_byte_load_group_decoder.sv
// self-checking testbench of the byte load group decoder
`default_nettype none
`define BLR_CHK(g, x) begin n_checks++; if ((g) !== (x)) begin n_mismatch++; \
   $display("unexpected at %0t: got %h expected %h", $time, g, x); end end
module tb_byte_load_group_decoder;
   timeunit 1ns;
   timeprecision 1ps;
   import blr_pkg::*;
   // msk bit 1 ignores dst, bit 0 ignores src
   typedef struct packed {logic bad; logic [1:0] msk; blr_res_t res;} blr_exp_t;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic slow = 1'b0;
   logic fetch_valid;
   logic [7:0] fetch_byte;
   logic [15:0] idx1 = 16'h0000;
   logic [15:0] idx2 = 16'h0000;
   logic opcode_fetch_cycle;
   logic dec_done;
   logic dec_bad;
   blr_res_t dec_res;
   blr_exp_t exp_q[$];
   logic ofc_q[$];
   int n_mismatch = 0;
   int n_checks = 0;
   int cycles = 0;
   blr_decoder blr_decoder_inst (.sys_clk(sys_clk), .rst(rst), .fetch_valid(fetch_valid),
      .fetch_byte(fetch_byte), .first_index_pointer(idx1), .second_index_pointer(idx2),
      .opcode_fetch_cycle(opcode_fetch_cycle), .dec_done(dec_done), .dec_bad(dec_bad),
      .dec_res(dec_res));
   blr_fetch_model blr_fetch_model_inst (.sys_clk(sys_clk), .rst(rst), .slow(slow),
      .fetch_valid(fetch_valid), .fetch_byte(fetch_byte));
   initial begin
      forever #4 sys_clk = ~sys_clk;
   end
   task automatic end_sim();
      if (n_mismatch == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : end_sim
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         end_sim();
      end
   end
   // scoreboard on taken bytes and results
   always @(posedge sys_clk) begin
      blr_exp_t e;
      blr_res_t got;
      logic of;
      if (rst === 1'b0 && fetch_valid === 1'b1) begin
         of = ofc_q.pop_front();
         `BLR_CHK(opcode_fetch_cycle, of)
      end
      if (dec_done === 1'b1 || dec_bad === 1'b1) begin
         e = exp_q.pop_front();
         `BLR_CHK({dec_bad, dec_done}, {e.bad, ~e.bad})
         got = dec_res;
         if (e.msk[1]) begin
            got.dst = 3'h0;
            e.res.dst = 3'h0;
         end
         if (e.msk[0]) begin
            got.src = 3'h0;
            e.res.src = 3'h0;
         end
         if (!e.bad) `BLR_CHK(got, e.res)
      end
   end
   function automatic blr_exp_t mk(blr_kind_t k, blr_ptr_t p, logic [2:0] d, logic [2:0] s,
         logic [7:0] n, logic [7:0] dp, logic [15:0] a, logic [2:0] l, logic [1:0] m);
      mk = '{1'b0, m, '{k, p, d, s, n, dp, a, l}};
   endfunction : mk
   task automatic send(input logic [7:0] b[$], input blr_exp_t e);
      foreach (b[i]) begin
         blr_fetch_model_inst.put(b[i]);
         ofc_q.push_back(i == 0);
      end
      exp_q.push_back(e);
   endtask : send
   task automatic idle();
      int k;
      for (k = 0; k < 300 && exp_q.size() != 0; k++) @(posedge sys_clk);
      repeat (2) @(posedge sys_clk);
      #1;
   endtask : idle
   initial begin
      logic [7:0] n;
      logic [7:0] lo;
      logic [7:0] hi;
      logic [7:0] d;
      logic [15:0] x;
      blr_kind_t k;
      int i;
      int j;
      void'($urandom(32'hfc70));
      repeat (20) @(posedge sys_clk);
      #1 rst = 1'b0;
      @(posedge sys_clk);
      #1;
      `BLR_CHK({opcode_fetch_cycle, dec_done, dec_bad, dec_res}, {3'b100, 48'h0})
      // register copies and pointer pair forms
      for (i = 0; i < 8; i++) for (j = 0; j < 8; j++) if (i != 6 || j != 6) begin
         k = (j == 6) ? BLR_K_LOAD_IND : (i == 6) ? BLR_K_STORE_IND : BLR_K_REG_REG;
         send('{{2'h1, i[2:0], j[2:0]}}, mk(k, (i == 6 || j == 6) ? BLR_P_PRIMARY
            : BLR_P_NONE, i[2:0], j[2:0], 0, 0, 0, 1, {i == 6, j == 6}));
      end
      send('{8'h72}, mk(BLR_K_STORE_IND, BLR_P_PRIMARY, 0, 3'h2, 0, 0, 0, 1, 2'b10));
      send('{8'h76}, '{1'b1, 2'b11, 48'h0});
      send('{8'hed, 8'h00}, '{1'b1, 2'b11, 48'h0});
      send('{8'hdd, 8'h00}, '{1'b1, 2'b11, 48'h0});
      // accumulator through bc and de pairs
      for (i = 0; i < 4; i++) begin
         k = (i < 2) ? BLR_K_LOAD_IND : BLR_K_STORE_IND;
         send('{{3'h0, i[0], ~i[1], 3'h2}}, mk(k, i[0] ? BLR_P_DE : BLR_P_BC,
            (i < 2) ? 3'h7 : 3'h0, (i < 2) ? 3'h0 : 3'h7, 0, 0, 0, 1, 0));
      end
      idle();
      slow = 1'b1;
      // immediate loads, registers and pointer pair
      for (i = 0; i < 8; i++) begin
         n = 8'($urandom);
         k = (i == 6) ? BLR_K_STORE_IND_IMM : BLR_K_REG_IMM;
         send('{{2'h0, i[2:0], 3'h6}, n}, mk(k, (i == 6) ? BLR_P_PRIMARY : BLR_P_NONE,
            i[2:0], 0, n, 0, 0, 2, {i == 6, 1'b1}));
      end
      for (i = 0; i < 2; i++) begin
         lo = 8'($urandom);
         hi = 8'($urandom);
         send('{i ? 8'h32 : 8'h3a, lo, hi}, mk(i ? BLR_K_STORE_EXT : BLR_K_LOAD_EXT, BLR_P_ABS,
            0, 0, 0, 0, {hi, lo}, 3, 2'b11));
      end
      for (i = 0; i < 4; i++) begin
         n = (i == 0) ? 8'h57 : (i == 1) ? 8'h5f : (i == 2) ? 8'h47 : 8'h4f;
         send('{8'hed, n}, mk(i < 2 ? BLR_K_LOAD_SPC : BLR_K_STORE_SPC, BLR_P_NONE,
            (i < 2) ? 3'h7 : {2'h0, i[0]}, (i < 2) ? {2'h0, i[0]} : 3'h7, 0, 0, 0, 2, 0));
      end
      for (i = 0; i < 6; i++) begin
         idle();
         idx1 = 16'($urandom);
         idx2 = 16'($urandom);
         d = (i < 2) ? 8'h80 : (i < 4) ? 8'h7f : 8'($urandom);
         n = $urandom;
         x = (i[0] ? idx2 : idx1) + {{8{d[7]}}, d};
         send('{i[0] ? 8'hfd : 8'hdd, 8'h7e, d}, mk(BLR_K_LOAD_IDX,
            i[0] ? BLR_P_IDX2 : BLR_P_IDX1, 3'h7, 0, 0, d, x, 3, 2'b01));
         send('{i[0] ? 8'hfd : 8'hdd, 8'h36, d, n}, mk(BLR_K_STORE_IDX_IMM,
            i[0] ? BLR_P_IDX2 : BLR_P_IDX1, 0, 0, n, d, x, 4, 2'b11));
         send('{i[0] ? 8'hfd : 8'hdd, {2'h1, 3'h6, i[2:0]}, d}, mk(BLR_K_STORE_IDX,
            i[0] ? BLR_P_IDX2 : BLR_P_IDX1, 0, i[2:0], 0, d, x, 3, 2'b10));
      end
      idle();
      `BLR_CHK(exp_q.size() + ofc_q.size(), 0)
      end_sim();
   end
endmodule : tb_byte_load_group_decoder
`default_nettype wire
